// ==== src/rac_core.sv ====
// Behaviour
// - fixed-zero bits always read back zero
// - reserved locations ignore writes, read zero
// - time and alarm fields kept as bcd
// - hours bit 6 high selects 12-hour
// - bit 5 is pm, or tens digit
// - alarm0 at 87h-8Ah, alarm1 at 8Bh-8Eh
// - unmasked alarm matches 00h-03h weekly
// - mask bit 7 drops field from compare
// - control read 0Fh, write 8Fh, bit map
// - write protect blocks all but itself
// - 1 Hz pin driven only when enabled
// - alarm0 pin low while flag and enable
// - alarm1 enable clear holds pin low
// - status at 10h shows both flags
// - alarm1 set gives 62.5 ms high pulse
// - alarm0 register access clears alarm0 flag
// - alarm1 register access clears alarm1 flag
// - charger needs key 1010 in upper nibble
// - diode field 01 or 10, else off
// - resistor field 00 disables charging
// - mode pin high spi, low 3-wire
// - clock and ram read/write address windows
// - alarm0 pin open drain, level held
`timescale 1ns/1ps
`default_nettype none
module rac_core #(
    parameter int unsigned PULSE_CYC = rac_pkg::PULSE_CYC_DFLT
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic osc_clk,
    input wire logic iface_protocol_sel,
    input wire rac_pkg::rac_serial_in_t ser_in,
    output logic sdo_o,
    output logic sdo_oe_n,
    output logic alarm0_irq_n,
    output logic alarm0_irq_oe_n,
    output logic sqw_o,
    output logic sqw_oe_n,
    output logic alarm1_pulse_out,
    output rac_pkg::rac_charger_t charger
);
    import rac_pkg::*;

    localparam int PW = $clog2(PULSE_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////
    // oscillator domain: reset sync and divider only, so little logic ever sees osc_clk
    typedef struct packed {
        logic rst_s1; // reset sync, first stage
        logic rst_s2; // reset sync, second stage
        logic [OSC_W-1:0] div; // free divider
    } rac_osc_t;

    rac_osc_t os_q, os_d;
    logic sqw_link; // 1 Hz square wave, oscillator domain

    // divide by 32768, msb is the square wave
    always_comb begin
        os_d = os_q;
        os_d.rst_s1 = nrst;
        os_d.rst_s2 = os_q.rst_s1;
        os_d.div = os_q.div + OSC_W'(1);
        if (!os_q.rst_s2) begin
            os_d.div = '0;
        end
    end

    // oscillator state register
    always_ff @(posedge osc_clk) begin
        os_q <= os_d;
    end

    assign sqw_link = os_q.div[OSC_W-1];

    ////////////////////////////////////////////////////////////////////////////
    // main domain state
    typedef struct packed {
        rac_serial_in_t ser_s1; // pin sync, first stage
        rac_serial_in_t ser_s2; // pin sync, second stage
        logic mode_s1; // protocol strap sync
        logic mode_s2;
        logic sqw_s1; // square wave crossing
        logic sqw_s2;
        logic sqw_prev; // edge detect on second stage
        logic sclk_prev; // serial clock edge detect
        rac_ser_state_t sstate; // serial frame state
        logic [2:0] bitcnt; // bit within byte
        logic [7:0] shin; // receive shifter
        logic [7:0] shout; // transmit shifter
        logic [7:0] addr; // current address byte
        logic sdo; // serial output bit
        logic sdo_drv; // output driver on
        logic [NUM_REGS-1:0][7:0] regs; // clock register file
        logic [RAM_WORDS-1:0][7:0] ram; // user memory
        logic [PW-1:0] pulse_cnt; // alarm1 pulse timer
        logic pulse; // alarm1 pin level
    } rac_state_t;

    rac_state_t q, d;
    logic tick; // one per second, after crossing
    logic rise, fall; // serial clock edges
    logic spi; // protocol in use
    logic [7:0] b; // byte being assembled
    logic [7:0] nxt; // incremented address
    logic rd_load, wr_fire; // byte boundary events
    logic [7:0] rd_addr, wr_addr;
    logic [6:0][7:0] t; // next time values
    logic c; // carry through the calendar
    logic [1:0] m; // alarm match on new time
    logic [1:0] set, acc; // flag set and clear causes
    logic wp; // write protect in force

    // bcd increment of one byte
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // last date of month, leap years where the bcd year divides by four
    function automatic logic [7:0] month_len(input logic [7:0] mo, input logic [7:0] yr);
        logic leap;
        leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8))
            || (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
        case (mo)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    // read value of one address, zero outside the populated windows
    function automatic logic [7:0] read_val(input logic [7:0] a, input rac_state_t s);
        if (a[6:5] != ADDR_CLK_REGION) begin
            read_val = s.ram[a[6:0] - RAM_BASE];
        end else if (a[4:0] < REG_RSV_FIRST) begin
            read_val = s.regs[a[4:0]];
        end else begin
            read_val = 8'h00;
        end
    endfunction

    // next state of the whole main domain
    always_comb begin
        d = q;
        b = 8'h00;
        nxt = 8'h00;
        rd_load = 1'b0;
        wr_fire = 1'b0;
        rd_addr = 8'h00;
        wr_addr = 8'h00;
        m = 2'b11;
        // synchronisers: stage one only feeds stage two
        d.ser_s1 = ser_in;
        d.ser_s2 = q.ser_s1;
        d.mode_s1 = iface_protocol_sel;
        d.mode_s2 = q.mode_s1;
        d.sqw_s1 = sqw_link;
        d.sqw_s2 = q.sqw_s1;
        d.sqw_prev = q.sqw_s2;
        d.sclk_prev = q.ser_s2.sclk;
        tick = q.sqw_s2 && !q.sqw_prev;
        rise = q.ser_s2.sclk && !q.sclk_prev;
        fall = !q.ser_s2.sclk && q.sclk_prev;
        spi = q.mode_s2;
        wp = q.regs[REG_CTRL][CTRL_WP];

        // timekeeping: advance a copy, all arithmetic in bcd
        t = q.regs[REG_YEAR:REG_SEC];
        c = (t[REG_SEC] == BCD_59);
        t[REG_SEC] = c ? 8'h00 : bcd_inc(t[REG_SEC]);
        if (c) begin
            c = (t[REG_MIN] == BCD_59);
            t[REG_MIN] = c ? 8'h00 : bcd_inc(t[REG_MIN]);
        end
        if (c) begin
            if (t[REG_HOUR][HOUR_12H]) begin
                c = 1'b0;
                if (t[REG_HOUR][4:0] == HR12_TOP) begin
                    t[REG_HOUR][4:0] = HR12_FIRST;
                end else if (t[REG_HOUR][4:0] == HR12_PRE) begin
                    // day rolls when 11 pm turns 12 am
                    c = t[REG_HOUR][HOUR_PM];
                    t[REG_HOUR][HOUR_PM] = !t[REG_HOUR][HOUR_PM];
                    t[REG_HOUR][4:0] = HR12_TOP;
                end else begin
                    t[REG_HOUR][4:0] = 5'(bcd_inc({3'b000, t[REG_HOUR][4:0]}));
                end
            end else begin
                // bit 5 acts as the tens-of-twenty digit here
                c = (t[REG_HOUR][5:0] == HR24_TOP);
                t[REG_HOUR][5:0] = c ? 6'h00 : 6'(bcd_inc({2'b00, t[REG_HOUR][5:0]}));
            end
        end
        if (c) begin
            t[REG_DAY] = (t[REG_DAY] == BCD_DAY_TOP) ? ONE_BCD : bcd_inc(t[REG_DAY]);
            c = (t[REG_DATE] == month_len(t[REG_MONTH], t[REG_YEAR]));
            t[REG_DATE] = c ? ONE_BCD : bcd_inc(t[REG_DATE]);
        end
        if (c) begin
            c = (t[REG_MONTH] == BCD_MONTH_TOP);
            t[REG_MONTH] = c ? ONE_BCD : bcd_inc(t[REG_MONTH]);
        end
        if (c) begin
            t[REG_YEAR] = (t[REG_YEAR] == BCD_99) ? 8'h00 : bcd_inc(t[REG_YEAR]);
        end
        if (tick) begin
            d.regs[REG_YEAR:REG_SEC] = t;
        end

        // compare the advanced time with both alarms, masked fields skipped
        for (int k = 0; k < 2; k++) begin
            for (int f = 0; f < 4; f++) begin
                if (!q.regs[A0_BASE + 4 * k + f][ALM_MASK]
                    && t[f][6:0] != q.regs[A0_BASE + 4 * k + f][6:0]) begin
                    m[k] = 1'b0;
                end
            end
        end
        set = tick ? m : 2'b00;

        // serial engine, sampled pins only
        if (!q.ser_s2.ce) begin
            // deselect ends the frame and releases the data pin
            d.sstate = SER_IDLE;
            d.bitcnt = 3'd0;
            d.sdo_drv = 1'b0;
        end else begin
            if (rise) begin
                // msb first for spi, lsb first for 3-wire
                b = spi ? {q.shin[6:0], q.ser_s2.sdi} : {q.ser_s2.sdi, q.shin[7:1]};
                d.shin = b;
                d.bitcnt = q.bitcnt + 3'd1;
                if (q.bitcnt == 3'd7) begin
                    case (q.sstate)
                        SER_IDLE: begin
                            d.addr = b;
                            d.sstate = SER_DATA;
                            rd_load = !b[ADDR_WR_BIT];
                            rd_addr = b;
                        end
                        SER_DATA: begin
                            // burst: step within the selected window
                            if (q.addr[6:5] == ADDR_CLK_REGION) begin
                                nxt = {q.addr[7:5], q.addr[4:0] + 5'd1};
                            end else if (q.addr[6:0] == RAM_TOP) begin
                                nxt = {q.addr[7], RAM_BASE};
                            end else begin
                                nxt = q.addr + 8'd1;
                            end
                            d.addr = nxt;
                            wr_fire = q.addr[ADDR_WR_BIT];
                            wr_addr = q.addr;
                            rd_load = !q.addr[ADDR_WR_BIT];
                            rd_addr = nxt;
                        end
                        default: begin
                            d.sstate = SER_IDLE;
                        end
                    endcase
                end
            end
            // next read bit goes out on the falling edge
            if (fall && q.sstate == SER_DATA && !q.addr[ADDR_WR_BIT]) begin
                d.sdo = spi ? q.shout[7] : q.shout[0];
                d.shout = spi ? {q.shout[6:0], 1'b0} : {1'b0, q.shout[7:1]};
                d.sdo_drv = 1'b1;
            end
        end
        if (rd_load) begin
            d.shout = read_val(rd_addr, q);
        end

        // host writes land after the tick, so a host write wins its register
        if (wr_fire) begin
            if (wr_addr[6:5] != ADDR_CLK_REGION) begin
                if (!wp) begin
                    d.ram[wr_addr[6:0] - RAM_BASE] = b;
                end
            end else if (wr_addr[4:0] == REG_CTRL) begin
                // the protect bit stays writable so software can get out
                d.regs[REG_CTRL][CTRL_WP] = b[CTRL_WP];
                if (!wp) begin
                    d.regs[REG_CTRL] = b & REG_MASK[REG_CTRL];
                end
            end else if (!wp && wr_addr[4:0] < REG_RSV_FIRST
                && wr_addr[4:0] != REG_FLAGS) begin
                d.regs[wr_addr[4:0]] = b & REG_MASK[wr_addr[4:0]];
            end
        end

        // any read or write of an alarm register clears its flag
        acc[0] = (rd_load && rd_addr[6:5] == ADDR_CLK_REGION
                && rd_addr[4:0] >= REG_A0_FIRST && rd_addr[4:0] <= REG_A0_LAST)
            || (wr_fire && wr_addr[6:5] == ADDR_CLK_REGION
                && wr_addr[4:0] >= REG_A0_FIRST && wr_addr[4:0] <= REG_A0_LAST);
        acc[1] = (rd_load && rd_addr[6:5] == ADDR_CLK_REGION
                && rd_addr[4:0] >= REG_A1_FIRST && rd_addr[4:0] <= REG_A1_LAST)
            || (wr_fire && wr_addr[6:5] == ADDR_CLK_REGION
                && wr_addr[4:0] >= REG_A1_FIRST && wr_addr[4:0] <= REG_A1_LAST);
        // a match in the clearing cycle still sets the flag
        d.regs[REG_FLAGS][FLAG_A0] = set[0] || (q.regs[REG_FLAGS][FLAG_A0] && !acc[0]);
        d.regs[REG_FLAGS][FLAG_A1] = set[1] || (q.regs[REG_FLAGS][FLAG_A1] && !acc[1]);

        // alarm1 pulse: retrigger on a new set, killed by the enable
        if (!d.regs[REG_CTRL][CTRL_ALARM1_IRQ_ENABLE]) begin
            d.pulse_cnt = '0;
        end else if (set[1]) begin
            d.pulse_cnt = PW'(PULSE_CYC);
        end else if (q.pulse_cnt != '0) begin
            d.pulse_cnt = q.pulse_cnt - PW'(1);
        end
        d.pulse = (d.pulse_cnt != '0);

        // synchronous reset; protect comes up set so nothing is written by accident
        if (!nrst) begin
            d = '0;
            d.regs[REG_CTRL] = CTRL_RESET;
            d.regs[REG_DAY] = ONE_BCD;
            d.regs[REG_DATE] = ONE_BCD;
            d.regs[REG_MONTH] = ONE_BCD;
        end
    end

    // main state register
    always_ff @(posedge clock) begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins
    assign sdo_o = q.sdo;
    assign sdo_oe_n = !(q.sdo_drv && q.ser_s2.ce);
    // open drain: only ever pulls low
    assign alarm0_irq_n = 1'b0;
    assign alarm0_irq_oe_n = !(q.regs[REG_FLAGS][FLAG_A0] && q.regs[REG_CTRL][CTRL_ALARM0_IRQ_ENABLE]);
    assign sqw_o = 1'b0;
    assign sqw_oe_n = !(q.regs[REG_CTRL][CTRL_1HZ] && !q.sqw_s2);
    assign alarm1_pulse_out = q.pulse;
    // charging needs the key, a diode path and a resistor together
    assign charger.diode_path_sel = q.regs[REG_CHG][3:2];
    assign charger.charge_resistor_sel = q.regs[REG_CHG][1:0];
    assign charger.enable = (q.regs[REG_CHG][7:4] == CHG_KEY)
        && (q.regs[REG_CHG][3:2] == DS_ONE || q.regs[REG_CHG][3:2] == DS_TWO)
        && (q.regs[REG_CHG][1:0] != RS_NONE);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_pulse_hold;
        $rose(alarm1_pulse_out) ##1 q.regs[REG_CTRL][CTRL_ALARM1_IRQ_ENABLE] [*7];
    endsequence

    property p_flag_set;
        tick && m[0] |=> q.regs[REG_FLAGS][FLAG_A0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("alarm0 flag not set");

    property p_flag_clear;
        acc[1] && !set[1] |=> !q.regs[REG_FLAGS][FLAG_A1];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("alarm1 flag kept");

    property p_alarm0_irq_n;
        q.regs[REG_FLAGS][FLAG_A0] && q.regs[REG_CTRL][CTRL_ALARM0_IRQ_ENABLE] |-> !alarm0_irq_oe_n;
    endproperty
    a_alarm0_irq_n: assert property (p_alarm0_irq_n) else $error("alarm0 pin not pulled");

    property p_alarm1_pulse_out_off;
        !q.regs[REG_CTRL][CTRL_ALARM1_IRQ_ENABLE] |-> !alarm1_pulse_out;
    endproperty
    a_alarm1_pulse_out_off: assert property (p_alarm1_pulse_out_off) else $error("alarm1 pin high while off");

    property p_alarm1_pulse_out_pulse;
        s_pulse_hold |-> alarm1_pulse_out;
    endproperty
    a_alarm1_pulse_out_pulse: assert property (p_alarm1_pulse_out_pulse) else $error("alarm1 pulse too short");

    property p_wp;
        wr_fire && wp |=> q.regs[REG_CTRL][2:0] == $past(q.regs[REG_CTRL][2:0]);
    endproperty
    a_wp: assert property (p_wp) else $error("protected control bits changed");

    property p_reserved;
        rd_load && rd_addr[6:5] == ADDR_CLK_REGION && rd_addr[4:0] >= REG_RSV_FIRST
            |=> q.shout == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved read not zero");

    property p_fixed_zero;
        (q.regs[REG_CTRL] & ~REG_MASK[REG_CTRL]) == 8'h00
            && (q.regs[REG_FLAGS] & ~REG_MASK[REG_FLAGS]) == 8'h00;
    endproperty
    a_fixed_zero: assert property (p_fixed_zero) else $error("fixed bit set");

    property p_sec_bcd;
        q.regs[REG_SEC][3:0] <= 4'h9 && q.regs[REG_SEC][6:4] <= 3'h5;
    endproperty
    a_sec_bcd: assert property (p_sec_bcd) else $error("seconds not bcd");

    property p_charger;
        q.regs[REG_CHG][7:4] != CHG_KEY |-> !charger.enable;
    endproperty
    a_charger: assert property (p_charger) else $error("charger on without key");
endmodule
`default_nettype wire

// ==== inc/rac_pkg.sv ====
`default_nettype none
package rac_pkg;
    // register indices inside the clock window (address bits 4:0)
    localparam logic [4:0] REG_SEC = 5'h00;
    localparam logic [4:0] REG_MIN = 5'h01;
    localparam logic [4:0] REG_HOUR = 5'h02;
    localparam logic [4:0] REG_DAY = 5'h03;
    localparam logic [4:0] REG_DATE = 5'h04;
    localparam logic [4:0] REG_MONTH = 5'h05;
    localparam logic [4:0] REG_YEAR = 5'h06;
    localparam logic [4:0] REG_A0_FIRST = 5'h07;
    localparam logic [4:0] REG_A0_LAST = 5'h0A;
    localparam logic [4:0] REG_A1_FIRST = 5'h0B;
    localparam logic [4:0] REG_A1_LAST = 5'h0E;
    localparam logic [4:0] REG_CTRL = 5'h0F;
    localparam logic [4:0] REG_FLAGS = 5'h10;
    localparam logic [4:0] REG_CHG = 5'h11;
    localparam logic [4:0] REG_RSV_FIRST = 5'h12;
    localparam int NUM_REGS = 18;
    localparam int A0_BASE = 7;
    localparam int A1_BASE = 11;
    // address byte layout
    localparam int ADDR_WR_BIT = 7;
    localparam logic [1:0] ADDR_CLK_REGION = 2'b00;
    localparam logic [6:0] RAM_BASE = 7'h20;
    localparam logic [6:0] RAM_TOP = 7'h7F;
    localparam int RAM_WORDS = 96;
    // writable bits of each register, index 17 down to 0
    localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {
        8'hFF, 8'h03, 8'h47, 8'h87, 8'hFF, 8'hFF, 8'hFF, 8'h87, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h1F, 8'h3F, 8'h07, 8'h7F, 8'h7F, 8'h7F};
    // field positions
    localparam int CTRL_WP = 6;
    localparam int CTRL_1HZ = 2;
    localparam int CTRL_ALARM1_IRQ_ENABLE = 1;
    localparam int CTRL_ALARM0_IRQ_ENABLE = 0;
    localparam int FLAG_A0 = 0;
    localparam int FLAG_A1 = 1;
    localparam int HOUR_12H = 6;
    localparam int HOUR_PM = 5;
    localparam int ALM_MASK = 7;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] ONE_BCD = 8'h01;
    // bcd limits
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] BCD_DAY_TOP = 8'h07;
    localparam logic [7:0] BCD_MONTH_TOP = 8'h12;
    localparam logic [4:0] HR12_TOP = 5'h12;
    localparam logic [4:0] HR12_PRE = 5'h11;
    localparam logic [4:0] HR12_FIRST = 5'h01;
    localparam logic [5:0] HR24_TOP = 6'h23;
    // charger decode
    localparam logic [3:0] CHG_KEY = 4'hA;
    localparam logic [1:0] DS_ONE = 2'b01;
    localparam logic [1:0] DS_TWO = 2'b10;
    localparam logic [1:0] RS_NONE = 2'b00;
    // timing
    localparam int OSC_DIV = 32768;
    localparam int OSC_W = $clog2(OSC_DIV);
    localparam int PULSE_US = 62500;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PULSE_CYC_DFLT = PULSE_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_DATA = 2'b01
    } rac_ser_state_t;

    typedef struct packed {
        logic ce;
        logic sclk;
        logic sdi;
    } rac_serial_in_t;

    typedef struct packed {
        logic enable;
        logic [1:0] diode_path_sel;
        logic [1:0] charge_resistor_sel;
    } rac_charger_t;
endpackage
`default_nettype wire

// ==== verification/rac_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rac_host
    import rac_pkg::*;
(
    input wire logic clock,
    input wire logic mode,
    input wire logic sdo_o,
    input wire logic sdo_oe_n,
    output var rac_serial_in_t ser
);
    logic ce = 1'b0; // low between frames
    logic sclk = 1'b0; // stands still outside frames
    logic drv = 1'b0; // host side of the data line
    // 3-wire shares one line; the device wins while it drives
    assign ser = '{ce, sclk, (!mode && !sdo_oe_n) ? sdo_o : drv};
    ////////////////////////////////////////
    // one frame: address then one data byte, sclk low for 6 clocks and high for 5 per bit
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        int b;
        w = {a, d};
        q = 8'h00;
        ce <= 1'b1;
        repeat (5) @(posedge clock);
        for (int i = 0; i < 16; i++) begin
            b = mode ? 7 - i % 8 : i % 8; // spi msb first, 3-wire lsb first
            // a read slot carries no data, so the line keeps changing
            drv <= (i < 8 || a[7]) ? w[b + (i < 8 ? 8 : 0)] : ~drv;
            sclk <= 1'b0;
            repeat (5) @(posedge clock);
            @(negedge clock);
            q[b] = mode ? sdo_o : ser.sdi;
            @(posedge clock);
            sclk <= 1'b1;
            repeat (5) @(posedge clock);
        end
        sclk <= 1'b0;
        repeat (5) @(posedge clock);
        ce <= 1'b0;
        drv <= ~drv; // a released line does not keep its value
        repeat (5) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rac_pkg::*;
    localparam int PC = 20; // short pulse keeps the run brief
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic osc_clk = 1'b0;
    logic mode = 1'b1;
    rac_serial_in_t ser;
    rac_charger_t charger;
    logic sdo_o, sdo_oe_n, a0_n, a0_oe_n, sqw_o, sqw_oe_n, pulse;
    logic [2:0] outs;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 99;
    int n;
    logic [7:0] r, v, ctl, chg;
    logic [7:0] hv [3] = '{8'h71, 8'h23, 8'h52}; // 12h pm 11, 24h 23, 12h am 12
    assign outs = {pulse, a0_oe_n, sqw_oe_n};
    always #50 clock = ~clock;
    // oscillator off-phase from the main clock
    initial begin
        #7;
        forever #16 osc_clk = ~osc_clk;
    end
    rac_core #(.PULSE_CYC(PC)) DUT (.clock(clock), .nrst(nrst), .osc_clk(osc_clk),
        .iface_protocol_sel(mode), .ser_in(ser), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
        .alarm0_irq_n(a0_n), .alarm0_irq_oe_n(a0_oe_n), .sqw_o(sqw_o), .sqw_oe_n(sqw_oe_n),
        .alarm1_pulse_out(pulse), .charger(charger));
    rac_host u_host (.clock(clock), .mode(mode), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .ser(ser));
    ////////////////////////////////////////
    task automatic print_verdict;
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_byte({7'h00, g}, {7'h00, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(a, d, r);
    endtask
    task automatic rd(input logic [7:0] a);
        u_host.xfer(a, 8'h00, r);
    endtask
    // bounded wait for a level; a miss ends the run
    task automatic wait_lvl(input int i, input logic lvl);
        for (n = 0; n < 12000 && outs[i] !== lvl; n++) @(negedge clock);
        chk_bit(outs[i], lvl);
        if (outs[i] !== lvl) print_verdict;
    endtask
    function automatic logic chg_en(input logic [7:0] c);
        return c[7:4] == CHG_KEY && (c[3:2] == DS_ONE || c[3:2] == DS_TWO) && c[1:0] != RS_NONE;
    endfunction
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        wr(8'h91, 8'hA5);
        rd(8'h11);
        chk_byte(r, 8'h00);
        wr(8'h8F, 8'h00);
        ctl = 8'h00;
        chg = 8'h00;
        for (int m = 1; m >= 0; m--) begin
            mode <= m[0];
            repeat (4) @(posedge clock);
            for (int k = 0; k < 6; k++) begin
                v = $random(seed);
                wr(8'h8F, v);
                ctl = ctl[6] ? {1'b0, v[6], ctl[5:0]} : v & 8'h47;
                rd(8'h0F);
                chk_byte(r, ctl);
                v = $random(seed);
                wr(8'h91, v);
                chg = ctl[6] ? chg : v;
                rd(8'h11);
                chk_byte(r, chg);
                chk_bit(charger.enable, chg_en(chg));
                chk_byte({4'h0, charger.diode_path_sel, charger.charge_resistor_sel}, chg & 8'h0F);
                wr(8'h92 + {5'h00, v[2:0]}, v);
                rd(8'h12 + {5'h00, v[2:0]});
                chk_byte(r, 8'h00);
            end
            $display("registers done, mode %0d", m);
        end
        wr(8'h8F, 8'h00);
        wr(8'h8F, 8'h00);
        wr(8'hE3, 8'h5A);
        rd(8'h63);
        chk_byte(r, 8'h5A);
        // alarm1 with all four fields masked fires each second
        wr(8'h8F, 8'h02);
        for (int k = 8'h8B; k <= 8'h8E; k++) wr(k[7:0], 8'h80);
        rd(8'h0B);
        wait_lvl(2, 1'b1);
        for (n = 0; n < 40 && outs[2] === 1'b1; n++) @(negedge clock);
        chk_byte(n[7:0], PC[7:0]);
        wr(8'h80, 8'h59);
        wr(8'h81, 8'h00);
        rd(8'h10);
        chk_byte(r, 8'h02);
        rd(8'h0B);
        rd(8'h10);
        chk_byte(r, 8'h00);
        wait_lvl(2, 1'b1);
        rd(8'h00);
        chk_byte(r, 8'h00);
        rd(8'h01);
        chk_byte(r, 8'h01);
        foreach (hv[i]) begin
            wr(8'h82, hv[i]);
            rd(8'h02);
            chk_byte(r, hv[i]);
        end
        $display("alarm1 and time done");
        wr(8'h8F, 8'h04);
        wait_lvl(0, 1'b0);
        wait_lvl(0, 1'b1);
        wr(8'h8F, 8'h00);
        v = 8'h00;
        // a full second: pulse and 1 Hz pins must stay quiet with enables clear
        repeat (11000) begin
            @(negedge clock);
            v = v | {6'h00, outs[2], ~outs[0]};
        end
        chk_byte(v, 8'h00);
        rd(8'h10);
        chk_byte(r, 8'h02);
        for (int k = 8'h87; k <= 8'h8A; k++) wr(k[7:0], 8'h80);
        wr(8'h8F, 8'h01);
        wait_lvl(1, 1'b0);
        repeat (50) @(negedge clock);
        chk_bit(a0_n, 1'b0);
        chk_bit(a0_oe_n, 1'b0);
        rd(8'h09);
        @(negedge clock);
        chk_bit(a0_oe_n, 1'b1);
        $display("alarm0 done");
        print_verdict;
    end
endmodule
`default_nettype wire
